// file: pkg/mdfm_pkg.sv
// Package: constants and types for the motor driver fault manager
package mdfm_pkg;
  localparam int unsigned CLK_MHZ = 125;
  // Deglitch times in ns: overcurrent fixed (pin) or selected by the deglitch field, converter fixed
  localparam int unsigned OC_DEG_FIXED_NS = 600;
  localparam int unsigned OC_DEG_NS_0 = 200;
  localparam int unsigned OC_DEG_NS_1 = 600;
  localparam int unsigned OC_DEG_NS_2 = 1000;
  localparam int unsigned OC_DEG_NS_3 = 1400;
  localparam int unsigned BK_DEG_NS = 1000;
  localparam int unsigned OC_DEG_CYC_FIXED = (OC_DEG_FIXED_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OC_DEG_CYC_0 = (OC_DEG_NS_0 * CLK_MHZ + 999) / 1000;
  localparam int unsigned OC_DEG_CYC_1 = (OC_DEG_NS_1 * CLK_MHZ + 999) / 1000;
  localparam int unsigned OC_DEG_CYC_2 = (OC_DEG_NS_2 * CLK_MHZ + 999) / 1000;
  localparam int unsigned OC_DEG_CYC_3 = (OC_DEG_NS_3 * CLK_MHZ + 999) / 1000;
  localparam int unsigned BK_DEG_CYC = (BK_DEG_NS * CLK_MHZ + 999) / 1000;
  // Millisecond tick for lock timing
  localparam int unsigned MS_TICK_CYC = CLK_MHZ * 1000;
  localparam int unsigned LOCK_FIXED_MS = 1000;
  localparam int unsigned DEG_W = 8;
  localparam int unsigned MS_W = 17;
  localparam int unsigned LOCK_W = 12;
  localparam int unsigned RETRY_W = 24;
  localparam logic [1:0] MODE_LATCH = 2'h0;
  localparam logic [1:0] MODE_RETRY = 2'h1;
  localparam logic [1:0] MODE_REPORT = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;
  localparam logic [1:0] OVERVOLT_LEVEL_SELECT_20V = 2'h0;
  localparam logic [1:0] OVERVOLT_LEVEL_SELECT_32V = 2'h1;
  localparam logic [1:0] OVERVOLT_LEVEL_SELECT_34V = 2'h2;
  typedef enum logic [1:0] {
    MDFM_IDLE = 2'b00,
    MDFM_SHUT = 2'b01,
    MDFM_RETRY = 2'b10,
    MDFM_REPORT = 2'b11
  } mdfm_state_e;
endpackage

// file: pkg/mdfm_resp_if.sv
// Interface: event and response signals between top and response machines
`timescale 1ns/1ps
`default_nettype none
interface mdfm_resp_if;
  logic event_p;
  logic cond;
  logic [1:0] mode;
  logic clear;
  logic [23:0] retry_cyc;
  logic shut;
  logic report;
  logic sticky_set;
  logic sticky_clr;
  modport top (output event_p, cond, mode, clear, retry_cyc,
               input shut, report, sticky_set, sticky_clr);
  modport fsm (input event_p, cond, mode, clear, retry_cyc,
               output shut, report, sticky_set, sticky_clr);
endinterface
`default_nettype wire

// file: rtl/mdfm_deglitch.sv
// Deglitch filter: qualifies a level held longer than a cycle count
`timescale 1ns/1ps
`default_nettype none
module mdfm_deglitch
  import mdfm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic level,
  input wire logic [DEG_W-1:0] limit,
  output logic qualified
);
  logic [DEG_W-1:0] cnt_q;
  // Counter saturates so a long fault keeps qualified high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (!level) begin
      cnt_q <= '0;
    end else if (cnt_q <= limit) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  assign qualified = level && (cnt_q > limit);
endmodule
`default_nettype wire

// file: rtl/mdfm_response.sv
// Response machine: latched, retry, report-only or disabled handling
`timescale 1ns/1ps
`default_nettype none
module mdfm_response
  import mdfm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  mdfm_resp_if.fsm rif
);
  mdfm_state_e state_q;
  logic [RETRY_W-1:0] cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= MDFM_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        MDFM_IDLE: begin
          cnt_q <= '0;
          if (rif.event_p) begin
            case (rif.mode)
              MODE_LATCH: state_q <= MDFM_SHUT;
              MODE_RETRY: state_q <= MDFM_RETRY;
              MODE_REPORT: state_q <= MDFM_REPORT;
              default: state_q <= MDFM_IDLE;
            endcase
          end
        end
        // Release needs condition gone and a clear; clear during fault is ignored
        MDFM_SHUT, MDFM_REPORT: begin
          if (rif.clear && !rif.cond) begin
            state_q <= MDFM_IDLE;
          end
        end
        MDFM_RETRY: begin
          if (cnt_q >= rif.retry_cyc) begin
            state_q <= MDFM_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: state_q <= MDFM_IDLE;
      endcase
    end
  end
  assign rif.shut = (state_q == MDFM_SHUT) || (state_q == MDFM_RETRY);
  assign rif.report = (state_q != MDFM_IDLE);
  assign rif.sticky_set = rif.event_p && (rif.mode != MODE_OFF);
  assign rif.sticky_clr = (state_q == MDFM_RETRY) && (cnt_q >= rif.retry_cyc);
endmodule
`default_nettype wire

// file: rtl/mdfm_fault_manager.sv
// Top: fault detection, response and status latching for the motor driver
//
// Functional notes
// - Pump low: FETs off, error low while present
// - Pump sticky until clear; always enabled
// - Overvoltage: FETs off, error low, sticky
// - Pin variant 34 V fixed; serial needs enable
// - Serial variant selects 20 V or 32 V
// - Overcurrent qualified after deglitch, response field
// - Pin variant: 16 A, 0.6 us, latched
// - Serial variant: level, deglitch, response configurable
// - Mode 00: shut, latch, clear after removal
// - Mode 01: shut, retry delay, bits stay
// - Mode 10: keep driving, report until clear
// - Mode 11: overcurrent ignored entirely
// - Converter overcurrent: retry, bits clear after
// - Lock after no halls; pin 1000 ms
// - Serial lock time and response configurable
// - Lock 00: shut until clear
// - Lock 01: retry, lock bit clears after delay, global fault stays
// - Lock 10: keep driving, report until clear
// - Warning sets bits; optional error report
// - Warning sticky until clear below trip
// - Shutdown: FETs and pump off, sticky
`timescale 1ns/1ps
`default_nettype none
module mdfm_fault_manager
  import mdfm_pkg::*;
#(
  parameter int unsigned MS_TICK = MS_TICK_CYC,
  parameter int unsigned OC_RETRY_CYC = 500000,
  parameter int unsigned BK_RETRY_CYC = 500000,
  parameter int unsigned LOCK_RETRY_CYC = 625000
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_variant,
  input wire logic pump_low_flag,
  input wire logic vm_over_20v,
  input wire logic vm_over_32v,
  input wire logic vm_over_34v,
  input wire logic overvolt_enable,
  input wire logic overvolt_level_select,
  input wire logic [2:0] fet_over_lo,
  input wire logic [2:0] fet_over_hi,
  input wire logic overcurrent_level,
  input wire logic [1:0] overcurrent_deglitch,
  input wire logic [1:0] overcurrent_response,
  input wire logic converter_over_raw,
  input wire logic [2:0] hall_in,
  input wire logic [LOCK_W-1:0] lock_time_ms,
  input wire logic [1:0] lock_response,
  input wire logic temp_warn_raw,
  input wire logic temp_warn_hys_raw,
  input wire logic temp_shut_raw,
  input wire logic temp_warning_report,
  input wire logic clear_faults_cmd,
  input wire logic sleep_reset_pulse,
  output logic error_out_n,
  output logic fets_enable,
  output logic converter_enable,
  output logic pump_enable,
  output logic global_fault,
  output logic pump_low_sticky,
  output logic overvolt_flag,
  output logic overcurrent_flag,
  output logic [2:0] fet_over_sticky,
  output logic converter_error_flag,
  output logic converter_overcurrent_flag,
  output logic lock_flag,
  output logic heat_summary_flag,
  output logic temp_warning_flag,
  output logic temp_shutdown_flag
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  localparam int unsigned NIN = 17;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  assign raw = {pump_low_flag, vm_over_20v, vm_over_32v, vm_over_34v, fet_over_lo,
                fet_over_hi, converter_over_raw, hall_in, temp_warn_raw,
                temp_warn_hys_raw, temp_shut_raw};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic pump_low, ov20, ov32, ov34, bk_raw, tw, tw_hys, ts;
  logic [2:0] oc_lo, oc_hi, hall;
  assign {pump_low, ov20, ov32, ov34, oc_lo, oc_hi, bk_raw, hall, tw, tw_hys, ts} = s2_q;
  logic clear;
  assign clear = clear_faults_cmd || sleep_reset_pulse;

  // ------------------------------------------------------------
  // Voltage and thermal conditions
  // ------------------------------------------------------------
  logic ov_cond;
  always_comb begin
    if (!serial_variant) begin
      ov_cond = ov34;
    end else begin
      ov_cond = overvolt_enable && (overvolt_level_select ? ov32 : ov20);
    end
  end
  // Warning report follows comparator with hysteresis
  logic tw_rep_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tw_rep_q <= 1'b0;
    end else if (tw) begin
      tw_rep_q <= 1'b1;
    end else if (!tw_hys) begin
      tw_rep_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Overcurrent deglitch and response
  // ------------------------------------------------------------
  function automatic logic [DEG_W-1:0] oc_deg_limit(input logic ser, input logic [1:0] sel);
    logic [DEG_W-1:0] v;
    v = DEG_W'(OC_DEG_CYC_FIXED);
    if (ser) begin
      case (sel)
        2'h0: v = DEG_W'(OC_DEG_CYC_0);
        2'h1: v = DEG_W'(OC_DEG_CYC_1);
        2'h2: v = DEG_W'(OC_DEG_CYC_2);
        default: v = DEG_W'(OC_DEG_CYC_3);
      endcase
    end
    return v;
  endfunction
  // Threshold choice: pin variant fixed at high level comparator
  logic [2:0] oc_lvl;
  assign oc_lvl = (serial_variant && !overcurrent_level) ? oc_lo : oc_hi;
  logic [2:0] oc_q;
  logic [DEG_W-1:0] oc_lim;
  assign oc_lim = oc_deg_limit(serial_variant, overcurrent_deglitch);
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_oc
      mdfm_deglitch u_deg (
        .clk(clk),
        .rst(rst),
        .level(oc_lvl[gi]),
        .limit(oc_lim),
        .qualified(oc_q[gi])
      );
    end
  endgenerate
  logic oc_any, oc_any_q, oc_ev;
  assign oc_any = |oc_q;
  logic bk_q, bk_q_d, bk_ev;
  mdfm_deglitch u_bk_deg (
    .clk(clk),
    .rst(rst),
    .level(bk_raw),
    .limit(DEG_W'(BK_DEG_CYC)),
    .qualified(bk_q)
  );

  // ------------------------------------------------------------
  // Lock detection
  // ------------------------------------------------------------
  logic [2:0] hall_q;
  logic [MS_W-1:0] div_q;
  logic [LOCK_W-1:0] lock_ms_q;
  logic ms_tick, lock_cond;
  logic [LOCK_W-1:0] lock_lim;
  assign ms_tick = (div_q == MS_W'(MS_TICK - 1));
  assign lock_lim = serial_variant ? lock_time_ms : LOCK_W'(LOCK_FIXED_MS);
  assign lock_cond = (lock_ms_q >= lock_lim);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hall_q <= '0;
      div_q <= '0;
      lock_ms_q <= '0;
    end else begin
      hall_q <= hall;
      // Divider restarts on each hall edge so a tick never cuts a short gap
      if (hall_q != hall) begin
        div_q <= '0;
        lock_ms_q <= '0;
      end else begin
        div_q <= ms_tick ? '0 : div_q + 1'b1;
        if (ms_tick && !lock_cond) begin
          lock_ms_q <= lock_ms_q + 1'b1;
        end
      end
    end
  end
  logic lock_q, lock_ev;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oc_any_q <= 1'b0;
      bk_q_d <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      oc_any_q <= oc_any;
      bk_q_d <= bk_q;
      lock_q <= lock_cond;
    end
  end
  assign oc_ev = oc_any && !oc_any_q;
  assign bk_ev = bk_q && !bk_q_d;
  assign lock_ev = lock_cond && !lock_q;

  // ------------------------------------------------------------
  // Response machines
  // ------------------------------------------------------------
  mdfm_resp_if oc_if();
  mdfm_resp_if bk_if();
  mdfm_resp_if lk_if();
  assign oc_if.event_p = oc_ev;
  assign oc_if.cond = oc_any;
  assign oc_if.mode = serial_variant ? overcurrent_response : MODE_LATCH;
  assign oc_if.clear = clear;
  assign oc_if.retry_cyc = RETRY_W'(OC_RETRY_CYC);
  assign bk_if.event_p = bk_ev;
  assign bk_if.cond = bk_q;
  assign bk_if.mode = MODE_RETRY;
  assign bk_if.clear = clear;
  assign bk_if.retry_cyc = RETRY_W'(BK_RETRY_CYC);
  assign lk_if.event_p = lock_ev;
  assign lk_if.cond = 1'b0; // Lock latch releases on clear alone
  assign lk_if.mode = serial_variant ? lock_response : MODE_LATCH;
  assign lk_if.clear = clear;
  assign lk_if.retry_cyc = RETRY_W'(LOCK_RETRY_CYC);
  mdfm_response u_oc (.clk(clk), .rst(rst), .rif(oc_if));
  mdfm_response u_bk (.clk(clk), .rst(rst), .rif(bk_if));
  mdfm_response u_lk (.clk(clk), .rst(rst), .rif(lk_if));

  // ------------------------------------------------------------
  // Sticky status; set wins over clear
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pump_low_sticky <= 1'b0;
      overvolt_flag <= 1'b0;
      overcurrent_flag <= 1'b0;
      fet_over_sticky <= '0;
      lock_flag <= 1'b0;
      temp_warning_flag <= 1'b0;
      temp_shutdown_flag <= 1'b0;
      converter_error_flag <= 1'b0;
      converter_overcurrent_flag <= 1'b0;
    end else begin
      pump_low_sticky <= pump_low || (pump_low_sticky && !clear);
      overvolt_flag <= ov_cond || (overvolt_flag && !clear);
      overcurrent_flag <= oc_if.sticky_set || (overcurrent_flag && !clear);
      fet_over_sticky <= (oc_if.sticky_set ? oc_q : 3'h0) | (fet_over_sticky & {3{!clear}});
      // Retry expiry also clears the lock bit
      lock_flag <= lk_if.sticky_set || (lock_flag && !clear && !lk_if.sticky_clr);
      // Warning stays while hot even through a clear
      temp_warning_flag <= tw || (temp_warning_flag && !clear);
      temp_shutdown_flag <= ts || (temp_shutdown_flag && !clear);
      converter_error_flag <= bk_if.sticky_set || (converter_error_flag && !bk_if.sticky_clr);
      converter_overcurrent_flag <= bk_if.sticky_set ||
                                    (converter_overcurrent_flag && !bk_if.sticky_clr);
    end
  end
  logic gf_set;
  assign gf_set = pump_low || ov_cond || oc_if.sticky_set || bk_if.sticky_set ||
                  lk_if.sticky_set || ts;
  logic gf_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gf_q <= 1'b0;
    end else begin
      gf_q <= gf_set || (gf_q && !clear && !(bk_if.sticky_clr && !overcurrent_flag &&
              !lock_flag && !pump_low_sticky && !overvolt_flag && !temp_shutdown_flag));
    end
  end
  assign global_fault = gf_q;

  // ------------------------------------------------------------
  // Drive enables and error output
  // ------------------------------------------------------------
  logic fet_off, err_req;
  assign fet_off = pump_low || ov_cond || oc_if.shut || lk_if.shut || ts;
  assign err_req = pump_low || ov_cond || oc_if.report || bk_if.report || lk_if.report ||
                   ts || (temp_warning_report && tw_rep_q);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      error_out_n <= 1'b1;
      fets_enable <= 1'b0;
      converter_enable <= 1'b0;
      pump_enable <= 1'b0;
      heat_summary_flag <= 1'b0;
    end else begin
      error_out_n <= !err_req;
      fets_enable <= !fet_off;
      converter_enable <= !bk_if.shut;
      pump_enable <= !ts;
      heat_summary_flag <= temp_warning_flag || temp_shutdown_flag || tw || ts;
    end
  end
endmodule
`default_nettype wire

// file: verification/mdfm_fault_manager_assertions.sv
// Port-level assertion checker for the motor driver fault manager
`timescale 1ns/1ps
`default_nettype none
module mdfm_chk
  import mdfm_pkg::*;
#(
  parameter int unsigned BK_RETRY_CYC = 20
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_variant,
  input wire logic pump_low_flag,
  input wire logic vm_over_34v,
  input wire logic [2:0] fet_over_lo,
  input wire logic [2:0] fet_over_hi,
  input wire logic [1:0] overcurrent_response,
  input wire logic temp_shut_raw,
  input wire logic clear_faults_cmd,
  input wire logic sleep_reset_pulse,
  input wire logic error_out_n,
  input wire logic fets_enable,
  input wire logic converter_enable,
  input wire logic pump_enable,
  input wire logic global_fault,
  input wire logic pump_low_sticky,
  input wire logic overvolt_flag,
  input wire logic overcurrent_flag,
  input wire logic converter_error_flag,
  input wire logic heat_summary_flag,
  input wire logic temp_warning_flag,
  input wire logic temp_shutdown_flag
);
  // ----
  // Helpers
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  localparam int BK_MAX = BK_RETRY_CYC + 16;
  logic clr;
  logic [7:0] oc_run_q;
  assign clr = clear_faults_cmd | sleep_reset_pulse;
  // Raw run length; saturates so long faults never wrap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oc_run_q <= 8'h00;
    end else if (!(|{fet_over_lo, fet_over_hi})) begin
      oc_run_q <= 8'h00;
    end else if (oc_run_q != 8'hFF) begin
      oc_run_q <= oc_run_q + 8'h01;
    end
  end
  sequence s_bk_trip;
    $rose(converter_error_flag) ##[0:1] !converter_enable;
  endsequence
  sequence s_bk_back;
    ##[1:BK_MAX] (!converter_error_flag && converter_enable);
  endsequence
  // ----
  // Assertions
  // ----
  AST_PUMP_TRIP: assert property (pump_low_flag [*5] |->
    !fets_enable && !error_out_n && pump_low_sticky && global_fault)
    else $error("pump low response missing");
  AST_PUMP_HOLD: assert property ($fell(pump_low_sticky) |->
    $past(clr) || $past(clr, 2)) else $error("pump sticky lost without clear");
  AST_OV_PIN: assert property ((!serial_variant && vm_over_34v) [*5] |->
    !fets_enable && overvolt_flag && !error_out_n) else $error("pin overvoltage missed");
  AST_OV_HOLD: assert property ($fell(overvolt_flag) |->
    $past(clr) || $past(clr, 2)) else $error("overvoltage sticky lost without clear");
  AST_TS_TRIP: assert property (temp_shut_raw [*5] |-> !fets_enable &&
    !pump_enable && temp_shutdown_flag && heat_summary_flag) else $error("shutdown missing");
  AST_OC_DEG: assert property ($rose(overcurrent_flag) |->
    oc_run_q >= 8'(OC_DEG_CYC_0)) else $error("overcurrent taken before deglitch");
  AST_OC_OFF: assert property ((serial_variant && overcurrent_response == MODE_OFF)
    [*8] |-> !$rose(overcurrent_flag)) else $error("disabled overcurrent reported");
  AST_BK_RETRY: assert property (s_bk_trip |-> s_bk_back)
    else $error("converter retry did not recover");
  AST_ERR_SRC: assert property ($fell(error_out_n) |-> ##[0:1]
    (global_fault || temp_warning_flag)) else $error("error output without source");
endmodule
bind mdfm_fault_manager mdfm_chk #(.BK_RETRY_CYC(BK_RETRY_CYC)) u_chk (
  .clk(clk), .rst(rst), .serial_variant(serial_variant), .pump_low_flag(pump_low_flag),
  .vm_over_34v(vm_over_34v), .fet_over_lo(fet_over_lo), .fet_over_hi(fet_over_hi),
  .overcurrent_response(overcurrent_response), .temp_shut_raw(temp_shut_raw),
  .clear_faults_cmd(clear_faults_cmd), .sleep_reset_pulse(sleep_reset_pulse),
  .error_out_n(error_out_n), .fets_enable(fets_enable), .converter_enable(converter_enable),
  .pump_enable(pump_enable), .global_fault(global_fault), .pump_low_sticky(pump_low_sticky),
  .overvolt_flag(overvolt_flag), .overcurrent_flag(overcurrent_flag),
  .converter_error_flag(converter_error_flag), .heat_summary_flag(heat_summary_flag),
  .temp_warning_flag(temp_warning_flag), .temp_shutdown_flag(temp_shutdown_flag));
`default_nettype wire

// file: verification/mdfm_ctrl_model.sv
// External controller model: clear requests and hall rotation
`timescale 1ns/1ps
`default_nettype none
module mdfm_ctrl_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic spin,
  input wire logic [1:0] clr_req,
  output logic clear_faults_cmd,
  output logic sleep_reset_pulse,
  output logic [2:0] hall_in
);
  // ----
  // Behaviour
  // ----
  logic [1:0] cnt_q;
  // Step every 4 cycles, far inside the lock time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 2'h0;
      hall_in <= 3'h1;
    end else if (spin) begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q == 2'h3) begin
        hall_in <= {hall_in[1:0], hall_in[2]};
      end
    end
  end
  // Sleep pulse arrives already decoded from a short high-low-high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clear_faults_cmd <= 1'h0;
      sleep_reset_pulse <= 1'h0;
    end else begin
      clear_faults_cmd <= clr_req[0];
      sleep_reset_pulse <= clr_req[1];
    end
  end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking testbench for the motor driver fault manager
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mdfm_pkg::*;
  // ----
  // Signals
  // ----
  logic clk = 1'h0, rst = 1'h1, spin = 1'h1;
  logic [1:0] clr_req = 2'h0;
  logic serial_variant = 1'h0, pump_low_flag = 1'h0, vm_over_20v = 1'h0, vm_over_32v = 1'h0;
  logic vm_over_34v = 1'h0, overvolt_enable = 1'h0, overvolt_level_select = 1'h0;
  logic [2:0] fet_over_lo = 3'h0, fet_over_hi = 3'h0;
  logic overcurrent_level = 1'h0, converter_over_raw = 1'h0, temp_warning_report = 1'h0;
  logic [1:0] overcurrent_deglitch = 2'h0, overcurrent_response = 2'h0, lock_response = 2'h0;
  logic [LOCK_W-1:0] lock_time_ms = 12'h001;
  logic temp_warn_raw = 1'h0, temp_warn_hys_raw = 1'h0, temp_shut_raw = 1'h0;
  logic clear_faults_cmd, sleep_reset_pulse, error_out_n, fets_enable, converter_enable;
  logic pump_enable, global_fault, pump_low_sticky, overvolt_flag, overcurrent_flag;
  logic converter_error_flag, converter_overcurrent_flag, lock_flag, heat_summary_flag;
  logic temp_warning_flag, temp_shutdown_flag;
  logic [2:0] hall_in, fet_over_sticky;
  int mismatches = 0, comparisons = 0, cycles = 0;
  // Bits: shut, serial, enable, select, over20, over32, over34
  logic [6:0] ovt [6] = '{7'h41, 7'h06, 7'h27, 7'h74, 7'h3C, 7'h7E};
  logic [2:0] oct [4] = '{3'h1, 3'h7, 3'h5, 3'h6};
  logic [2:0] lka [4] = '{3'h1, 3'h1, 3'h5, 3'h6};
  logic [2:0] lkb [4] = '{3'h1, 3'h6, 3'h5, 3'h6};
  // ----
  // Instances
  // ----
  mdfm_fault_manager #(.MS_TICK(10), .OC_RETRY_CYC(20), .BK_RETRY_CYC(20),
    .LOCK_RETRY_CYC(80)) DUT (
    .clk(clk), .rst(rst), .serial_variant(serial_variant), .pump_low_flag(pump_low_flag),
    .vm_over_20v(vm_over_20v), .vm_over_32v(vm_over_32v), .vm_over_34v(vm_over_34v),
    .overvolt_enable(overvolt_enable), .overvolt_level_select(overvolt_level_select),
    .fet_over_lo(fet_over_lo), .fet_over_hi(fet_over_hi), .overcurrent_level(overcurrent_level),
    .overcurrent_deglitch(overcurrent_deglitch), .overcurrent_response(overcurrent_response),
    .converter_over_raw(converter_over_raw), .hall_in(hall_in), .lock_time_ms(lock_time_ms),
    .lock_response(lock_response), .temp_warn_raw(temp_warn_raw),
    .temp_warn_hys_raw(temp_warn_hys_raw), .temp_shut_raw(temp_shut_raw),
    .temp_warning_report(temp_warning_report), .clear_faults_cmd(clear_faults_cmd),
    .sleep_reset_pulse(sleep_reset_pulse), .error_out_n(error_out_n),
    .fets_enable(fets_enable), .converter_enable(converter_enable), .pump_enable(pump_enable),
    .global_fault(global_fault), .pump_low_sticky(pump_low_sticky),
    .overvolt_flag(overvolt_flag), .overcurrent_flag(overcurrent_flag),
    .fet_over_sticky(fet_over_sticky), .converter_error_flag(converter_error_flag),
    .converter_overcurrent_flag(converter_overcurrent_flag), .lock_flag(lock_flag),
    .heat_summary_flag(heat_summary_flag), .temp_warning_flag(temp_warning_flag),
    .temp_shutdown_flag(temp_shutdown_flag));
  mdfm_ctrl_model u_ctrl (.clk(clk), .rst(rst), .spin(spin), .clr_req(clr_req),
    .clear_faults_cmd(clear_faults_cmd), .sleep_reset_pulse(sleep_reset_pulse),
    .hall_in(hall_in));
  // ----
  // Tasks
  // ----
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic clr(input logic [1:0] k);
    @(posedge clk) clr_req <= k;
    @(posedge clk) clr_req <= 2'h0;
    cyc(4);
  endtask
  task automatic oc(input logic [2:0] v);
    fet_over_lo <= v;
    fet_over_hi <= v;
  endtask
  task automatic conclude();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Ceiling well above the longest path through the sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      conclude();
    end
  end
  // ----
  // Sequence
  // ----
  initial begin
    cyc(20);
    rst <= 1'h0;
    cyc(4);
    chk({fets_enable, error_out_n, pump_enable, global_fault}, 4'hE);
    pump_low_flag <= 1'h1;
    cyc(8);
    chk({fets_enable, error_out_n, pump_low_sticky, global_fault}, 4'h3);
    pump_low_flag <= 1'h0;
    cyc(8);
    chk({fets_enable, error_out_n, pump_low_sticky}, 3'h7);
    clr(2'h1);
    chk({pump_low_sticky, global_fault}, 2'h0);
    for (int i = 0; i < 6; i++) begin
      {serial_variant, overvolt_enable, overvolt_level_select, vm_over_20v, vm_over_32v,
        vm_over_34v} <= ovt[i][5:0];
      cyc(8);
      chk({fets_enable, overvolt_flag}, {~ovt[i][6], ovt[i][6]});
      {vm_over_20v, vm_over_32v, vm_over_34v} <= 3'h0;
      cyc(8);
      chk({fets_enable, error_out_n, overvolt_flag}, {2'h3, ovt[i][6]});
      clr(2'h2);
    end
    // Low comparator alone must not trip while the high level is chosen
    overcurrent_level <= 1'h1;
    fet_over_lo <= 3'h2;
    cyc(40);
    oc(3'h2);
    cyc(12);
    oc(3'h0);
    cyc(8);
    chk(overcurrent_flag, 1'h0);
    overcurrent_level <= 1'h0;
    for (int m = 0; m < 4; m++) begin
      overcurrent_response <= 2'(m);
      oc(3'h2);
      cyc(40);
      chk({fets_enable, error_out_n, overcurrent_flag}, lka[m]);
      oc(3'h0);
      cyc(60);
      chk({oct[m], fet_over_sticky}, {oct[m], oct[m][0] ? 3'h2 : 3'h0});
      chk({fets_enable, error_out_n, overcurrent_flag}, oct[m]);
      clr(2'h1);
      chk({fets_enable, error_out_n, overcurrent_flag}, 3'h6);
    end
    serial_variant <= 1'h0;
    oc(3'h2);
    cyc(60);
    chk(overcurrent_flag, 1'h0);
    cyc(40);
    chk({fets_enable, error_out_n, overcurrent_flag}, 3'h1);
    oc(3'h0);
    cyc(60);
    chk(fets_enable, 1'h0);
    clr(2'h2);
    chk(fets_enable, 1'h1);
    serial_variant <= 1'h1;
    for (int m = 0; m < 4; m++) begin
      lock_response <= 2'(m);
      spin <= 1'h0;
      cyc(40);
      chk({fets_enable, error_out_n, lock_flag}, lka[m]);
      spin <= 1'h1;
      cyc(100);
      chk({fets_enable, error_out_n, lock_flag}, lkb[m]);
      clr(2'h1);
      chk({fets_enable, error_out_n, lock_flag}, 3'h6);
    end
    temp_warning_report <= 1'h1;
    {temp_warn_raw, temp_warn_hys_raw} <= 2'h3;
    cyc(8);
    chk({fets_enable, error_out_n, temp_warning_flag, heat_summary_flag}, 4'hB);
    clr(2'h1);
    chk(temp_warning_flag, 1'h1);
    temp_warn_raw <= 1'h0;
    cyc(8);
    chk(error_out_n, 1'h0);
    temp_warn_hys_raw <= 1'h0;
    cyc(8);
    chk({error_out_n, temp_warning_flag}, 2'h3);
    clr(2'h2);
    chk(temp_warning_flag, 1'h0);
    temp_warning_report <= 1'h0;
    {temp_warn_raw, temp_warn_hys_raw} <= 2'h3;
    cyc(8);
    chk({fets_enable, error_out_n, temp_warning_flag}, 3'h7);
    {temp_warn_raw, temp_warn_hys_raw} <= 2'h0;
    clr(2'h1);
    temp_shut_raw <= 1'h1;
    cyc(8);
    chk({fets_enable, pump_enable, error_out_n, temp_shutdown_flag}, 4'h1);
    temp_shut_raw <= 1'h0;
    cyc(8);
    chk({fets_enable, pump_enable, error_out_n, temp_shutdown_flag}, 4'hF);
    clr(2'h2);
    chk({temp_shutdown_flag, heat_summary_flag}, 2'h0);
    converter_over_raw <= 1'h1;
    cyc(140);
    chk({fets_enable, converter_enable, error_out_n, converter_error_flag,
      converter_overcurrent_flag}, 5'h13);
    converter_over_raw <= 1'h0;
    cyc(60);
    chk({converter_enable, error_out_n, converter_error_flag,
      converter_overcurrent_flag}, 4'hC);
    serial_variant <= 1'h0;
    spin <= 1'h0;
    cyc(9980);
    chk(lock_flag, 1'h0);
    cyc(60);
    chk({fets_enable, error_out_n, lock_flag}, 3'h1);
    conclude();
  end
endmodule
`default_nettype wire
